/* File: rtl/console_pkg.sv */
package console_pkg;

	// ******************************************************************
	// Status display codes, binary weighted, bit 3 first indicator.
	// ******************************************************************
	localparam logic [3:0] CODE_NONE     = 4'h0;
	localparam logic [3:0] CODE_CPU      = 4'h1;
	localparam logic [3:0] CODE_MEM      = 4'h2;
	localparam logic [3:0] CODE_TX_WAIT  = 4'h3;
	localparam logic [3:0] CODE_RX_WAIT  = 4'h4;
	localparam logic [3:0] CODE_LOAD_ERR = 4'h5;
	localparam logic [3:0] CODE_BOOT_BAD = 4'h6;
	localparam logic [3:0] CODE_NET_HOST = 4'h7;
	localparam logic [3:0] CODE_NET_MSG  = 4'h8;
	localparam logic [3:0] CODE_NET_PROC = 4'h9;
	localparam logic [3:0] CODE_ROM_BOOT = 4'hA;
	localparam logic [3:0] CODE_LOW_MEM  = 4'hB;
	localparam logic [3:0] CODE_HUNG     = 4'hF;
	localparam logic [1:0] RUN_MODE      = 2'h2;

	// ******************************************************************
	// Monitor constants.
	// ******************************************************************
	localparam int         WORD_W        = 16;
	localparam logic [15:0] TRAP_AREA_END = 16'h0040;
	localparam logic [3:0] DIGITS        = 4'h6;
	localparam logic [3:0] PROMPT_END    = 4'h9;
	localparam logic [7:0] CHR_CR        = 8'h0D;
	localparam logic [7:0] CHR_LF        = 8'h0A;
	localparam logic [7:0] CHR_AT        = 8'h40;
	localparam logic [7:0] CHR_SLASH     = 8'h2F;
	localparam logic [7:0] CHR_GO_UP     = 8'h47;
	localparam logic [7:0] CHR_GO_LO     = 8'h67;
	localparam logic [7:0] CHR_ZERO      = 8'h30;
	localparam logic [7:0] CHR_SEVEN     = 8'h37;
	localparam logic [7:0] CHR_QUERY     = 8'h3F;

	typedef enum logic [2:0]
	{
		MON_RUN   = 3'h0,
		MON_PRINT = 3'h1,
		MON_CMD   = 3'h3,
		MON_READ  = 3'h2,
		MON_OPEN  = 3'h6,
		MON_WRITE = 3'h7
	} mon_state_t;

endpackage

/* File: rtl/status_if.sv */
`timescale 1ns/1ps
interface status_if;
	logic       cpu_fail;
	logic       mem_fail;
	logic       low_mem_fail;
	logic       load_err;
	logic       boot_bad;
	logic       net_boot;
	logic       tx_wait;
	logic       rx_wait;
	logic       net_host;
	logic       net_msg;
	logic       net_proc;
	logic       hung;
	logic       halt_sw;
	logic [1:0] mode;
	logic [3:0] code;
	logic       fatal;

	modport top
	(
		output cpu_fail, mem_fail, low_mem_fail, load_err, boot_bad, net_boot,
		output tx_wait, rx_wait, net_host, net_msg, net_proc, hung, halt_sw, mode,
		input  code, fatal
	);
	modport disp
	(
		input  cpu_fail, mem_fail, low_mem_fail, load_err, boot_bad, net_boot,
		input  tx_wait, rx_wait, net_host, net_msg, net_proc, hung, halt_sw, mode,
		output code, fatal
	);
endinterface

/* File: rtl/status_display.sv */
`timescale 1ns/1ps
module status_display
(
	input  wire logic clk_in,
	input  wire logic srst_in,
	status_if.disp    st
);

	typedef struct packed
	{
		logic [3:0] fail_code;
		logic       fatal;
		logic [3:0] code;
	} disp_t;

	disp_t s_reg;
	disp_t s_next;

	always_comb
	begin
		s_next = s_reg;
		// ******************************************************************
		// Fatal failures latch and stop the processor.
		// ******************************************************************
		if (!s_reg.fatal)
		begin
			if (st.cpu_fail)
			begin
				s_next.fail_code = console_pkg::CODE_CPU;
				s_next.fatal     = 1'b1;
			end
			else if (st.mem_fail)
			begin
				s_next.fail_code = console_pkg::CODE_MEM;
				s_next.fatal     = 1'b1;
			end
			else if (st.low_mem_fail)
			begin
				s_next.fail_code = console_pkg::CODE_LOW_MEM;
				s_next.fatal     = 1'b1;
			end
			else if (st.load_err && !st.net_boot)
			begin
				s_next.fail_code = console_pkg::CODE_LOAD_ERR;
				s_next.fatal     = 1'b1;
			end
			else if (st.boot_bad && !st.net_boot)
			begin
				s_next.fail_code = console_pkg::CODE_BOOT_BAD;
				s_next.fatal     = 1'b1;
			end
		end
		// ******************************************************************
		// Display priority; the unused boot code is never chosen.
		// ******************************************************************
		if (st.hung || st.halt_sw || st.mode != console_pkg::RUN_MODE)
			s_next.code = console_pkg::CODE_HUNG;
		else if (s_next.fatal)
			s_next.code = s_next.fail_code;
		else if (st.load_err)
			s_next.code = console_pkg::CODE_LOAD_ERR;
		else if (st.boot_bad)
			s_next.code = console_pkg::CODE_BOOT_BAD;
		else if (st.net_boot && st.net_proc)
			s_next.code = console_pkg::CODE_NET_PROC;
		else if (st.net_boot && st.net_msg)
			s_next.code = console_pkg::CODE_NET_MSG;
		else if (st.net_boot && st.net_host)
			s_next.code = console_pkg::CODE_NET_HOST;
		else if (st.rx_wait)
			s_next.code = console_pkg::CODE_RX_WAIT;
		else if (st.tx_wait)
			s_next.code = console_pkg::CODE_TX_WAIT;
		else
			s_next.code = console_pkg::CODE_NONE;
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign st.code  = s_reg.code;
	assign st.fatal = s_reg.fatal;

endmodule // status_display

/* File: rtl/console_monitor_and_led_status.sv */
`timescale 1ns/1ps
//
// Contract
// - Four indicators show code, first is MSB.
// - Codes 01/02 for CPU/memory failure, halt.
// - Code 03 while polling transmitter ready.
// - Code 04 while polling receiver done.
// - Code 05 load error, 06 bad bootstrap.
// - Code 07 network boot awaiting host.
// - Codes 10/11 network message wait/processing.
// - Code 12 reserved, never displayed.
// - Code 13 low memory test fails.
// - Code 17 hung, halt switch, wrong mode.
// - Code means running or failed; network retries.
// - Halt below 100 octal traps to dialog.
// - Four causes enter monitor mode.
// - Commands ignored outside monitor mode.
// - Entry prints next location, then prompt.
// - Address slash opens, prints six digits.
// - Value plus return writes; return closes.
// - Address G initializes and starts there.
module console_monitor_and_led_status
(
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic        halt_switch_in,
	input  wire logic [1:0]  power_mode_in,
	input  wire logic        cpu_fail_in,
	input  wire logic        mem_fail_in,
	input  wire logic        low_mem_fail_in,
	input  wire logic        load_err_in,
	input  wire logic        boot_bad_in,
	input  wire logic        net_boot_in,
	input  wire logic        tx_wait_in,
	input  wire logic        rx_wait_in,
	input  wire logic        net_host_in,
	input  wire logic        net_msg_in,
	input  wire logic        net_proc_in,
	input  wire logic        hung_in,
	input  wire logic        break_in,
	input  wire logic        break_halt_en_in,
	input  wire logic        halt_instr_in,
	input  wire logic        error_in,
	input  wire logic [15:0] next_pc_in,
	input  wire logic        rx_valid_in,
	input  wire logic [7:0]  rx_data_in,
	input  wire logic        tx_ready_in,
	input  wire logic        mem_ack_in,
	input  wire logic [15:0] mem_rdata_in,
	output logic      [3:0]  status_led_out,
	output logic             cpu_halt_out,
	output logic             monitor_mode_out,
	output logic             trap_dialog_out,
	output logic             tx_valid_out,
	output logic      [7:0]  tx_data_out,
	output logic             mem_req_out,
	output logic             mem_we_out,
	output logic      [15:0] mem_addr_out,
	output logic      [15:0] mem_wdata_out,
	output logic             sys_init_out,
	output logic             go_out,
	output logic      [15:0] go_addr_out
);

	// ******************************************************************
	// State.
	// ******************************************************************
	typedef struct packed
	{
		logic                   hs1;
		logic                   hs2;
		logic                   hs_prev;
		console_pkg::mon_state_t st;
		logic [15:0]            addr;
		logic [15:0]            val;
		logic                   have_val;
		logic [15:0]            pr_word;
		logic [3:0]             pr_idx;
		logic                   pr_prompt;
		logic                   tx_valid;
		logic [7:0]             tx_data;
		logic                   mem_req;
		logic                   mem_we;
		logic [15:0]            mem_addr;
		logic [15:0]            mem_wdata;
		logic                   init;
		logic                   go;
		logic [15:0]            go_addr;
		logic                   trap;
		logic                   in_mon;
		logic [3:0]             led;
		logic                   halt;
	} mon_t;

	mon_t       s_reg;
	mon_t       s_next;
	status_if   sif ();
	logic       is_digit;
	logic       cause;
	logic       dialog_cause;
	logic [7:0] pr_char;

	function automatic logic [7:0] print_char(input logic [15:0] w, input logic [3:0] i);
		logic [17:0] x;
		logic [4:0]  sh;
		x  = {2'b00, w};
		sh = 5'h0;
		if (i < console_pkg::DIGITS)
		begin
			sh = 5'(15 - 3 * int'(i));
			return console_pkg::CHR_ZERO + {5'h00, 3'(x >> sh)};
		end
		else if (i == 4'h6)
			return console_pkg::CHR_CR;
		else if (i == 4'h7)
			return console_pkg::CHR_LF;
		else
			return console_pkg::CHR_AT;
	endfunction

	// ******************************************************************
	// Status display.
	// ******************************************************************
	assign sif.cpu_fail     = cpu_fail_in;
	assign sif.mem_fail     = mem_fail_in;
	assign sif.low_mem_fail = low_mem_fail_in;
	assign sif.load_err     = load_err_in;
	assign sif.boot_bad     = boot_bad_in;
	assign sif.net_boot     = net_boot_in;
	assign sif.tx_wait      = tx_wait_in;
	assign sif.rx_wait      = rx_wait_in;
	assign sif.net_host     = net_host_in;
	assign sif.net_msg      = net_msg_in;
	assign sif.net_proc     = net_proc_in;
	assign sif.hung         = hung_in;
	assign sif.halt_sw      = s_reg.hs2;
	assign sif.mode         = power_mode_in;

	status_display u_disp
	(
		.clk_in  (clk_in),
		.srst_in (srst_in),
		.st      (sif.disp)
	);

	// ******************************************************************
	// Monitor sequencing.
	// ******************************************************************
	assign is_digit     = rx_data_in >= console_pkg::CHR_ZERO && rx_data_in <= console_pkg::CHR_SEVEN;
	assign dialog_cause = halt_instr_in || error_in;
	assign cause        = (break_in && break_halt_en_in) || dialog_cause
	                      || (s_reg.hs2 && !s_reg.hs_prev);
	assign pr_char      = print_char(s_reg.pr_word, s_reg.pr_idx);

	always_comb
	begin
		s_next         = s_reg;
		s_next.hs1     = halt_switch_in;
		s_next.hs2     = s_reg.hs1;
		s_next.hs_prev = s_reg.hs2;
		s_next.init    = 1'b0;
		s_next.go      = 1'b0;
		s_next.trap    = 1'b0;
		s_next.led     = sif.code;
		s_next.halt    = sif.fatal || s_reg.in_mon;
		if (s_reg.tx_valid && tx_ready_in)
			s_next.tx_valid = 1'b0;
		unique case (s_reg.st)
			console_pkg::MON_RUN:
			begin
				if (cause)
				begin
					if (dialog_cause && next_pc_in < console_pkg::TRAP_AREA_END)
						s_next.trap = 1'b1;
					else
					begin
						s_next.in_mon    = 1'b1;
						s_next.pr_word   = next_pc_in;
						s_next.pr_idx    = 4'h0;
						s_next.pr_prompt = 1'b1;
						s_next.st        = console_pkg::MON_PRINT;
					end
				end
			end
			console_pkg::MON_PRINT:
			begin
				if (!s_reg.tx_valid || tx_ready_in)
				begin
					if (s_reg.pr_idx == (s_reg.pr_prompt ? console_pkg::PROMPT_END
					                                     : console_pkg::DIGITS))
					begin
						s_next.st       = s_reg.pr_prompt ? console_pkg::MON_CMD
						                                  : console_pkg::MON_OPEN;
						s_next.addr     = 16'h0000;
						s_next.val      = 16'h0000;
						s_next.have_val = 1'b0;
					end
					else
					begin
						s_next.tx_valid = 1'b1;
						s_next.tx_data  = pr_char;
						s_next.pr_idx   = s_reg.pr_idx + 4'h1;
					end
				end
			end
			console_pkg::MON_CMD:
			begin
				if (rx_valid_in)
				begin
					if (is_digit)
						s_next.addr = {s_reg.addr[12:0], rx_data_in[2:0]};
					else if (rx_data_in == console_pkg::CHR_SLASH)
					begin
						s_next.mem_req  = 1'b1;
						s_next.mem_we   = 1'b0;
						s_next.mem_addr = s_reg.addr;
						s_next.st       = console_pkg::MON_READ;
					end
					else if (rx_data_in == console_pkg::CHR_GO_UP
					         || rx_data_in == console_pkg::CHR_GO_LO)
					begin
						s_next.init    = 1'b1;
						s_next.go      = 1'b1;
						s_next.go_addr = s_reg.addr;
						s_next.in_mon  = 1'b0;
						s_next.st      = console_pkg::MON_RUN;
					end
					else if (rx_data_in == console_pkg::CHR_CR)
					begin
						s_next.pr_idx    = console_pkg::DIGITS;
						s_next.pr_prompt = 1'b1;
						s_next.st        = console_pkg::MON_PRINT;
					end
					else
					begin
						s_next.pr_word   = 16'h0000;
						s_next.pr_idx    = 4'h5;
						s_next.pr_prompt = 1'b1;
						s_next.tx_valid  = 1'b1;
						s_next.tx_data   = console_pkg::CHR_QUERY;
						s_next.st        = console_pkg::MON_PRINT;
					end
				end
			end
			console_pkg::MON_READ:
			begin
				if (mem_ack_in)
				begin
					s_next.mem_req   = 1'b0;
					s_next.pr_word   = mem_rdata_in;
					s_next.pr_idx    = 4'h0;
					s_next.pr_prompt = 1'b0;
					s_next.st        = console_pkg::MON_PRINT;
				end
			end
			console_pkg::MON_OPEN:
			begin
				if (rx_valid_in)
				begin
					if (is_digit)
					begin
						s_next.val      = {s_reg.val[12:0], rx_data_in[2:0]};
						s_next.have_val = 1'b1;
					end
					else if (rx_data_in == console_pkg::CHR_CR)
					begin
						if (s_reg.have_val)
						begin
							s_next.mem_req   = 1'b1;
							s_next.mem_we    = 1'b1;
							s_next.mem_wdata = s_reg.val;
							s_next.st        = console_pkg::MON_WRITE;
						end
						else
						begin
							s_next.pr_idx    = console_pkg::DIGITS;
							s_next.pr_prompt = 1'b1;
							s_next.st        = console_pkg::MON_PRINT;
						end
					end
				end
			end
			console_pkg::MON_WRITE:
			begin
				if (mem_ack_in)
				begin
					s_next.mem_req   = 1'b0;
					s_next.mem_we    = 1'b0;
					s_next.pr_idx    = console_pkg::DIGITS;
					s_next.pr_prompt = 1'b1;
					s_next.st        = console_pkg::MON_PRINT;
				end
			end
			default:
			begin
				s_next.st = console_pkg::MON_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	// ******************************************************************
	// Outputs.
	// ******************************************************************
	assign status_led_out   = s_reg.led;
	assign cpu_halt_out     = s_reg.halt;
	assign monitor_mode_out = s_reg.in_mon;
	assign trap_dialog_out  = s_reg.trap;
	assign tx_valid_out     = s_reg.tx_valid;
	assign tx_data_out      = s_reg.tx_data;
	assign mem_req_out      = s_reg.mem_req;
	assign mem_we_out       = s_reg.mem_we;
	assign mem_addr_out     = s_reg.mem_addr;
	assign mem_wdata_out    = s_reg.mem_wdata;
	assign sys_init_out     = s_reg.init;
	assign go_out           = s_reg.go;
	assign go_addr_out      = s_reg.go_addr;

endmodule // console_monitor_and_led_status

/* File: test/console_monitor_and_led_status_monitor.sv */
`timescale 1ns/1ps
// ****************************************
// Port checker for the console block.
// ****************************************
module led_console_checker
(
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic [1:0]  power_mode_in,
	input  wire logic        hung_in,
	input  wire logic        halt_instr_in,
	input  wire logic        error_in,
	input  wire logic [15:0] next_pc_in,
	input  wire logic        tx_ready_in,
	input  wire logic        mem_ack_in,
	input  wire logic [3:0]  status_led_out,
	input  wire logic        cpu_halt_out,
	input  wire logic        monitor_mode_out,
	input  wire logic        trap_dialog_out,
	input  wire logic        tx_valid_out,
	input  wire logic [7:0]  tx_data_out,
	input  wire logic        mem_req_out,
	input  wire logic        mem_we_out,
	input  wire logic [15:0] mem_addr_out,
	input  wire logic        sys_init_out,
	input  wire logic        go_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	sequence s_fatal_held;
		(hung_in || power_mode_in != 2'h2) [*4];
	endsequence
	sequence s_run_cause;
		!monitor_mode_out && !cpu_halt_out && (halt_instr_in || error_in);
	endsequence
	hung_code_a: assert property (s_fatal_held |-> status_led_out == 4'hF)
		else $error("all indicators not lit");
	reserved_code_a: assert property (status_led_out != 4'hA)
		else $error("reserved code shown");
	fatal_hold_a: assert property (cpu_halt_out && !monitor_mode_out &&
		status_led_out inside {4'h1, 4'h2} |=> cpu_halt_out) else $error("halt released");
	tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
		tx_valid_out && $stable(tx_data_out)) else $error("character dropped");
	monitor_entry_a: assert property (s_run_cause ##0 next_pc_in >= 16'h0040 |=>
		monitor_mode_out && !trap_dialog_out) else $error("monitor not entered");
	trap_return_a: assert property (s_run_cause ##0 next_pc_in < 16'h0040 |=>
		trap_dialog_out && !monitor_mode_out) else $error("trap return missing");
	idle_commands_a: assert property (!monitor_mode_out |-> !mem_req_out)
		else $error("memory access outside monitor");
	go_start_a: assert property (go_out |-> sys_init_out && !monitor_mode_out &&
		$past(monitor_mode_out)) else $error("bad start");
	mem_hold_a: assert property (mem_req_out && !mem_ack_in |=> mem_req_out &&
		$stable(mem_addr_out) && $stable(mem_we_out)) else $error("request changed");
endmodule // led_console_checker

/* File: test/console_terminal.sv */
`timescale 1ns/1ps
// ****************************************
// Operator terminal model.
// ****************************************
module console_terminal
(
	input  wire logic       clk_in,
	input  wire logic       slow_in,
	output logic            tx_ready_out,
	output logic            rx_valid_out,
	output logic      [7:0] rx_data_out
);
	initial
	begin
		tx_ready_out = 1'b1;
		rx_valid_out = 1'b0;
		rx_data_out = 8'h00;
	end
	always @(posedge clk_in)
		tx_ready_out <= !slow_in || ($urandom % 3 == 0);
	task type_char(input logic [7:0] c);
		@(posedge clk_in);
		rx_valid_out <= 1'b1;
		rx_data_out <= c;
		@(posedge clk_in);
		rx_valid_out <= 1'b0;
		rx_data_out <= ~c;
	endtask
	task type_val(input logic [15:0] v, input logic [7:0] t);
		for (int i = 0; i < 6; i++)
			type_char(8'h30 | {5'h00, 3'(v >> (15 - 3 * i))});
		type_char(t);
	endtask
endmodule // console_terminal

/* File: test/test_console_monitor_and_led_status.sv */
`timescale 1ns/1ps
// ****************************************
// Console block bench.
// ****************************************
module test_console_monitor_and_led_status;
	logic        clk_in, srst_in, halt_switch_in, break_in, break_halt_en_in, halt_instr_in;
	logic        error_in, rx_valid_in, tx_ready_in, mem_ack_in, slow, ack;
	logic        cpu_fail_in, mem_fail_in, low_mem_fail_in, load_err_in, boot_bad_in;
	logic        net_boot_in, tx_wait_in, rx_wait_in, net_host_in, net_msg_in, net_proc_in;
	logic        hung_in, cpu_halt_out, monitor_mode_out, trap_dialog_out, tx_valid_out;
	logic        mem_req_out, mem_we_out, sys_init_out, go_out;
	logic [1:0]  power_mode_in;
	logic [3:0]  status_led_out;
	logic [7:0]  rx_data_in, tx_data_out;
	logic [15:0] next_pc_in, mem_rdata_in, mem_addr_out, mem_wdata_out, go_addr_out;
	logic [15:0] rdata, a, v, pc;
	logic [32:0] memq[$];
	logic [15:0] goq[$];
	logic [7:0]  txq[$];
	logic [18:0] tab[19];
	int          fails, comparisons, traps;

	console_monitor_and_led_status dut (.*);
	console_terminal term (.clk_in(clk_in), .slow_in(slow), .tx_ready_out(tx_ready_in),
		.rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in));

	initial
	begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	task check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task report_and_stop;
		if (fails == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task setv(input logic [13:0] x);
		{hung_in, net_proc_in, net_msg_in, net_host_in, rx_wait_in, tx_wait_in, net_boot_in,
			boot_bad_in, load_err_in, low_mem_fail_in, mem_fail_in, cpu_fail_in,
			power_mode_in} <= x;
	endtask
	task rst;
		srst_in <= 1'b1;
		repeat (16) @(posedge clk_in);
		check("reset_outputs", {status_led_out, monitor_mode_out, tx_valid_out}, 0);
		srst_in <= 1'b0;
	endtask
	task pulse(input int k);
		@(posedge clk_in);
		{error_in, halt_instr_in, break_in} <= 3'h1 << k;
		@(posedge clk_in);
		{error_in, halt_instr_in, break_in} <= 3'h0;
	endtask
	task word(input logic [15:0] x);
		for (int i = 0; i < 6; i++)
			txq.push_back(8'h30 | {5'h00, 3'(x >> (15 - 3 * i))});
	endtask
	task prompt;
		txq.push_back(8'h0D);
		txq.push_back(8'h0A);
		txq.push_back(8'h40);
	endtask
	task drain;
		for (int n = 0; n < 2000 && txq.size() != 0; n++)
			@(posedge clk_in);
		check("tx_drained", txq.size(), 0);
		repeat (3) @(posedge clk_in);
	endtask

	// Memory side and result watcher.
	always @(posedge clk_in)
	begin
		ack = mem_req_out && !mem_ack_in && ($urandom % 2 == 0);
		mem_ack_in <= ack;
		mem_rdata_in <= ack ? rdata : ~rdata;
		if (!srst_in)
		begin
			if (trap_dialog_out)
				traps++;
			if (tx_valid_out && tx_ready_in)
				check("tx_data", tx_data_out, txq.size() ? txq.pop_front() : 8'hFF);
			if (mem_req_out && mem_ack_in)
				check("mem_cycle", {mem_we_out, mem_addr_out, mem_we_out ? mem_wdata_out
					: 16'h0}, memq.size() ? memq.pop_front() : '1);
			if (go_out)
				check("go_addr", go_addr_out, goq.size() ? goq.pop_front() : '1);
		end
	end
	initial
	begin
		repeat (20000) @(posedge clk_in);
		fails++;
		report_and_stop();
	end

	initial
	begin
		{halt_switch_in, break_in, break_halt_en_in, halt_instr_in, error_in, slow} = '0;
		{mem_ack_in, fails, comparisons, traps, rdata, next_pc_in, mem_rdata_in} = '0;
		setv(14'h0002);
		srst_in = 1'b1;
		void'($urandom(52966));
		tab = '{{12'h040, 7'h46}, {12'h080, 7'h48}, {12'h0C0, 7'h48}, {12'h120, 7'h4E},
			{12'h220, 7'h50}, {12'h420, 7'h52}, {12'h028, 7'h4A}, {12'h030, 7'h4C},
			{12'h100, 7'h40}, {12'h800, 7'h5E}, {12'h000, 7'h1E}, {12'h000, 7'h3E},
			{12'h000, 7'h7E}, {12'h002, 7'h45}, {12'h001, 7'h43}, {12'h004, 7'h57},
			{12'h008, 7'h4B}, {12'h010, 7'h4D}, {12'h003, 7'h43}};
		rst();
		for (int i = 0; i < 19; i++)
		begin
			@(posedge clk_in);
			setv(tab[i][18:5]);
			repeat (4) @(posedge clk_in);
			check("status_led", status_led_out, tab[i][4:1]);
			setv(14'h0002);
			repeat (4) @(posedge clk_in);
			check("status_led_after", status_led_out, tab[i][0] ? tab[i][4:1] : 4'h0);
			if (tab[i][4:1] inside {4'h1, 4'h2})
				check("cpu_halt", cpu_halt_out, tab[i][0]);
			if (tab[i][0])
				rst();
		end
		pulse(0);
		term.type_val(16'h0007, 8'h2F);
		repeat (6) @(posedge clk_in);
		check("monitor_mode", monitor_mode_out, 1'b0);
		for (int c = 0; c < 4; c++)
		begin
			slow <= c[0];
			pc = (c == 1) ? 16'h0040 : (16'($urandom) | 16'h0040);
			next_pc_in <= pc;
			word(pc);
			prompt();
			case (c)
				0: begin break_halt_en_in <= 1'b1; pulse(0); end
				1: pulse(1);
				2: pulse(2);
				default: halt_switch_in <= 1'b1;
			endcase
			drain();
			check("monitor_mode", monitor_mode_out, 1'b1);
			if (c == 3)
				check("status_led", status_led_out, 4'hF);
			if (c == 0)
			begin
				a = 16'($urandom);
				rdata = 16'($urandom);
				v = 16'($urandom);
				memq.push_back({1'b0, a, 16'h0});
				word(rdata);
				term.type_val(a, 8'h2F);
				drain();
				memq.push_back({1'b1, a, v});
				prompt();
				term.type_val(v, 8'h0D);
				drain();
				rdata = v;
				memq.push_back({1'b0, a, 16'h0});
				word(v);
				term.type_val(a, 8'h2F);
				drain();
				prompt();
				term.type_char(8'h0D);
				drain();
				txq.push_back(8'h3F);
				txq.push_back(8'h30);
				prompt();
				term.type_char(8'h78);
				drain();
			end
			a = 16'($urandom);
			goq.push_back(a);
			term.type_val(a, c[0] ? 8'h67 : 8'h47);
			repeat (4) @(posedge clk_in);
			check("go_done", {monitor_mode_out, goq.size()}, 0);
		end
		halt_switch_in <= 1'b0;
		next_pc_in <= 16'h003F;
		pulse(1);
		repeat (6) @(posedge clk_in);
		check("trap_count", {monitor_mode_out, traps}, 1);
		report_and_stop();
	end
endmodule // test_console_monitor_and_led_status

bind console_monitor_and_led_status led_console_checker chk (.*);
